// *** rtl/ipx_ctrl.sv ***
`timescale 1ns/1ps
`include "ipx_map.svh"
module ipx_ctrl #(
    parameter int NSRC = 16
) (
    input  wire logic            hclk,
    input  wire logic            hresetn,
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic [31:0]          hrdata,
    output logic                 hresp,
    input  wire logic [NSRC-1:0] src_set,
    input  wire logic [7:0]      port_pins,
    input  wire logic            cpu_stall,
    input  wire logic            cpu_return_from_interrupt,
    input  wire logic            cpu_insn_done,
    output ipx_pkg::ipx_vec_t    vec,
    output logic                 call_busy,
    output logic                 irq
);
    import ipx_pkg::*;

    default clocking a_clk @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    localparam int IDW = 5;

    if (NSRC < 2 || NSRC > 24) begin : g_chk
        $error("NSRC must lie in 2..24");
    end

    logic [NSRC-1:0]      pend_q;
    logic [NSRC-1:0]      en_q;
    logic                 gie_q;
    logic [23:0]          prio_q;
    ipx_extcfg_t          cfg_q;
    logic [`IPX_EV_W-1:0] istat_q;
    logic [`IPX_EV_W-1:0] istat_d;
    logic [`IPX_EV_W-1:0] imask_q;
    logic [`IPX_EV_W-1:0] ev;
    logic [1:0]           in_svc_q;
    logic                 hold_q;
    ipx_state_t           state_q;
    logic [2:0]           cnt_q;
    logic [IDW-1:0]       cur_id_q;
    logic                 cur_high_q;
    ipx_vec_t             vec_q;
    logic                 busy_q;
    logic                 irq_q;
    logic [31:0]          hrdata_q;
    logic [31:0]          rd_mux;
    logic                 wr_q;
    logic [7:0]           waddr_q;
    logic                 boot_q;
    logic [7:0]           pin_s1_q;
    logic [7:0]           pin_s2_q;
    logic [1:0]           act_q;
    logic [1:0]           ext_act;
    logic [1:0]           ext_edge;

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic acc;
    logic rd_acc;
    logic rd_istat;
    logic w_pend;
    logic w_en;
    logic w_ctrl;
    logic w_cfg;
    logic w_mask;
    logic [2:0] w_prio;

    assign acc      = hsel && hready && htrans[1];
    assign rd_acc   = acc && !hwrite;
    assign rd_istat = rd_acc && (haddr[7:0] == `IPX_OFF_ISTAT);
    assign w_pend   = wr_q && (waddr_q == `IPX_OFF_PEND);
    assign w_en     = wr_q && (waddr_q == `IPX_OFF_EN);
    assign w_ctrl   = wr_q && (waddr_q == `IPX_OFF_CTRL);
    assign w_cfg    = wr_q && (waddr_q == `IPX_OFF_CFG);
    assign w_mask   = wr_q && (waddr_q == `IPX_OFF_IMASK);
    assign w_prio[0] = wr_q && (waddr_q == `IPX_OFF_PRIO0);
    assign w_prio[1] = wr_q && (waddr_q == `IPX_OFF_PRIO1);
    assign w_prio[2] = wr_q && (waddr_q == `IPX_OFF_PRIO2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q    <= 1'b0;
            waddr_q <= 8'h00;
        end else begin
            wr_q <= acc && hwrite;
            if (acc) begin
                waddr_q <= haddr[7:0];
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0;
        case (haddr[7:0])
            `IPX_OFF_PEND:  rd_mux = 32'(pend_q);
            `IPX_OFF_EN:    rd_mux = 32'(en_q);
            `IPX_OFF_CTRL:  rd_mux = 32'(gie_q);
            `IPX_OFF_PRIO0: rd_mux = 32'(prio_q[7:0]);
            `IPX_OFF_PRIO1: rd_mux = 32'(prio_q[15:8]);
            `IPX_OFF_PRIO2: rd_mux = 32'(prio_q[23:16]);
            `IPX_OFF_CFG:   rd_mux = 32'(cfg_q);
            `IPX_OFF_STATE: rd_mux = 32'({in_svc_q, hold_q, busy_q,
                                          cur_high_q, cur_id_q});
            `IPX_OFF_ISTAT: rd_mux = 32'(istat_q);
            `IPX_OFF_IMASK: rd_mux = 32'(imask_q);
            default:        rd_mux = 32'h0;
        endcase
    end

    // zero wait state: read data is registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0;
        end else if (rd_acc) begin
            hrdata_q <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q    <= '0;
            gie_q   <= 1'b0;
            prio_q  <= {3{`IPX_RST_PRIO}};
            cfg_q   <= `IPX_RST_CFG;
            imask_q <= `IPX_RST_MASK;
        end else begin
            if (w_en) begin
                en_q <= hwdata[NSRC-1:0];
            end
            if (w_ctrl) begin
                gie_q <= hwdata[`IPX_CTRL_GIE];
            end
            if (w_prio[0]) begin
                prio_q[7:0] <= hwdata[7:0];
            end
            if (w_prio[1]) begin
                prio_q[15:8] <= hwdata[7:0];
            end
            if (w_prio[2]) begin
                prio_q[23:16] <= hwdata[7:0];
            end
            if (w_cfg) begin
                cfg_q <= ipx_extcfg_t'(hwdata[9:0]);
            end
            if (w_mask) begin
                imask_q <= hwdata[`IPX_EV_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // external inputs
    // ----------------------------------------------------------------
    logic [1:0] trig;
    logic [1:0] pol;
    logic [2:0] sel [2];

    assign trig   = {cfg_q.trig_b, cfg_q.trig_a};
    assign pol    = {cfg_q.pol_b, cfg_q.pol_a};
    assign sel[0] = cfg_q.sel_a;
    assign sel[1] = cfg_q.sel_b;

    // pins are only observed; owner of the pin is not disturbed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_q <= 8'h00;
            pin_s2_q <= 8'h00;
        end else begin
            pin_s1_q <= port_pins;
            pin_s2_q <= pin_s1_q;
        end
    end

    for (genvar k = 0; k < 2; k++) begin : g_ext
        // polarity one means active high
        assign ext_act[k]  = pin_s2_q[sel[k]] ~^ pol[k];
        assign ext_edge[k] = trig[k] && ext_act[k] && !act_q[k];
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                act_q[k] <= 1'b0;
            end else begin
                act_q[k] <= ext_act[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // pending flags
    // ----------------------------------------------------------------
    logic vec_take;

    for (genvar i = 0; i < NSRC; i++) begin : g_pend
        logic set_i;
        logic clr_i;
        if (i < 2) begin : g_x
            // set wins over clear so no edge is lost
            assign set_i = ext_edge[i] || (w_pend && hwdata[i]);
            assign clr_i = (w_pend && !hwdata[i]) ||
                           (vec_take && cur_id_q == IDW'(i));
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pend_q[i] <= 1'b0;
                end else if (!trig[i]) begin
                    // level source must hold until taken
                    pend_q[i] <= ext_act[i];
                end else if (set_i) begin
                    pend_q[i] <= 1'b1;
                end else if (clr_i) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end else begin : g_h
            assign set_i = src_set[i] || (w_pend && hwdata[i]);
            assign clr_i = w_pend && !hwdata[i];
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pend_q[i] <= 1'b0;
                end else if (set_i) begin
                    pend_q[i] <= 1'b1;
                end else if (clr_i) begin
                    pend_q[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // priority decode
    // ----------------------------------------------------------------
    function automatic logic [IDW:0] pick(input logic [NSRC-1:0] m);
        logic [IDW:0] r;
        r = '0;
        for (int j = NSRC - 1; j >= 0; j--) begin
            if (m[j]) begin
                r = {1'b1, IDW'(j)};
            end
        end
        return r;
    endfunction

    logic [NSRC-1:0] req;
    logic [NSRC-1:0] prio;
    logic [NSRC-1:0] cand_hi;
    logic [NSRC-1:0] cand_lo;
    logic [IDW:0]    pk_hi;
    logic [IDW:0]    pk_lo;
    logic            go;

    assign prio    = prio_q[NSRC-1:0];
    assign req     = pend_q & en_q & {NSRC{gie_q}};
    // high waits only for high; low waits for anything in service
    assign cand_hi = in_svc_q[1] ? '0 : (req & prio);
    assign cand_lo = (|in_svc_q) ? '0 : (req & ~prio);
    assign pk_hi   = pick(cand_hi);
    assign pk_lo   = pick(cand_lo);
    assign go      = (state_q == S_IDLE) && !hold_q && !cpu_stall &&
                     (pk_hi[IDW] || pk_lo[IDW]);

    // ----------------------------------------------------------------
    // call sequencing
    // ----------------------------------------------------------------
    assign vec_take = (state_q == S_CALL) && !cpu_stall &&
                      (cnt_q == 3'd1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= S_IDLE;
            cnt_q      <= 3'd0;
            cur_id_q   <= '0;
            cur_high_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (go) begin
                        state_q    <= S_CALL;
                        cnt_q      <= `IPX_CALL_CYC;
                        cur_high_q <= pk_hi[IDW];
                        cur_id_q   <= pk_hi[IDW] ? pk_hi[IDW-1:0]
                                                 : pk_lo[IDW-1:0];
                    end
                end
                S_CALL: begin
                    // a stall freezes the count, adding its length
                    if (!cpu_stall) begin
                        cnt_q <= cnt_q - 3'd1;
                        if (cnt_q == 3'd1) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_svc_q <= 2'b00;
        end else if (vec_take) begin
            in_svc_q[cur_high_q] <= 1'b1;
        end else if (cpu_return_from_interrupt) begin
            if (in_svc_q[1]) begin
                in_svc_q[1] <= 1'b0;
            end else begin
                in_svc_q[0] <= 1'b0;
            end
        end
    end

    // after a return, one instruction must finish before the next call;
    // the cpu's own return and divide cycles make up the worst case
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 1'b0;
        end else if (cpu_return_from_interrupt) begin
            hold_q <= 1'b1;
        end else if (cpu_insn_done) begin
            hold_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vec_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            vec_q.valid <= vec_take;
            if (vec_take) begin
                vec_q.id   <= cur_id_q;
                vec_q.high <= cur_high_q;
            end
            busy_q <= go || ((state_q == S_CALL) && !vec_take);
        end
    end

    // ----------------------------------------------------------------
    // event status and interrupt output
    // ----------------------------------------------------------------
    always_comb begin
        ev                 = '0;
        ev[`IPX_EV_TAKE]   = vec_take;
        ev[`IPX_EV_RETURN_FROM_INTERRUPT]   = cpu_return_from_interrupt;
        ev[`IPX_EV_EDGE_A] = ext_edge[0];
        ev[`IPX_EV_EDGE_B] = ext_edge[1];
        istat_d = (istat_q & ~{`IPX_EV_W{rd_istat}}) | ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_q <= '0;
            irq_q   <= 1'b0;
            boot_q  <= 1'b0;
        end else begin
            istat_q <= istat_d;
            irq_q   <= |(istat_q & imask_q);
            boot_q  <= 1'b1;
        end
    end

    assign hreadyout = boot_q || !boot_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign vec       = vec_q;
    assign call_busy = busy_q;
    assign irq       = irq_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_call_length: assert property (
        go ##1 (!cpu_stall)[*5] |=> vec_q.valid)
        else $error("call did not complete in five clocks");
    a_stall_freeze: assert property (
        (state_q == S_CALL && cpu_stall) |=> $stable(cnt_q) && !vec_q.valid)
        else $error("call advanced during stall");
    a_high_no_preempt: assert property (
        (in_svc_q[1] && !cpu_return_from_interrupt && state_q == S_IDLE)
        |=> state_q == S_IDLE)
        else $error("high routine preempted");
    a_high_first: assert property (
        (go && |cand_hi) |=> cur_high_q)
        else $error("low request chosen over high");
    a_hold_blocks: assert property (
        cpu_return_from_interrupt ##1 (!cpu_insn_done)[*2] |-> state_q == S_IDLE && !busy_q)
        else $error("call started before next instruction");
    a_sw_set_pend: assert property (
        (w_pend && hwdata[NSRC-1]) |=> pend_q[NSRC-1])
        else $error("software set of pending flag lost");
    a_level_follow: assert property (
        !cfg_q.trig_a |=> pend_q[0] == $past(ext_act[0]))
        else $error("level flag does not follow input");
    a_edge_clear: assert property (
        (vec_take && cur_id_q == '0 && cfg_q.trig_a && !ext_edge[0] &&
         !(w_pend && hwdata[0])) |=> !pend_q[0])
        else $error("edge flag not cleared on vectoring");
    a_edge_set: assert property (
        (ext_edge[1] && cfg_q.trig_b) |=> pend_q[1] && istat_q[3])
        else $error("edge on input b not caught");
    a_reset_low: assert property (
        !boot_q |-> prio_q == 24'h0)
        else $error("priority not low after reset");
    a_irq_level: assert property (
        ##1 irq_q == $past(|(istat_q & imask_q)))
        else $error("interrupt output mismatch");

endmodule

// *** rtl/ipx_map.svh ***
`ifndef IPX_MAP_SVH
`define IPX_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IPX_OFF_PEND   8'h00
`define IPX_OFF_EN     8'h04
`define IPX_OFF_CTRL   8'h08
`define IPX_OFF_PRIO0  8'h0c
`define IPX_OFF_PRIO1  8'h10
`define IPX_OFF_PRIO2  8'h14
`define IPX_OFF_CFG    8'h18
`define IPX_OFF_STATE  8'h1c
`define IPX_OFF_ISTAT  8'h20
`define IPX_OFF_IMASK  8'h24

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IPX_CTRL_GIE   0
`define IPX_EV_TAKE    0
`define IPX_EV_RETURN_FROM_INTERRUPT    1
`define IPX_EV_EDGE_A  2
`define IPX_EV_EDGE_B  3
`define IPX_EV_W       4
`define IPX_RST_PRIO   8'h00
`define IPX_RST_CFG    10'h000
`define IPX_RST_MASK   4'h0

// ----------------------------------------------------------------
// timing counts in system clocks
// ----------------------------------------------------------------
`define IPX_DETECT_CYC 1
`define IPX_CALL_CYC   3'd5

`endif

// *** rtl/ipx_pkg.sv ***
package ipx_pkg;

    typedef enum logic {
        S_IDLE,
        S_CALL
    } ipx_state_t;

    // layout of the external input configuration register
    typedef struct packed {
        logic [2:0] sel_b;
        logic [2:0] sel_a;
        logic       pol_b;
        logic       pol_a;
        logic       trig_b;
        logic       trig_a;
    } ipx_extcfg_t;

    typedef struct packed {
        logic       valid;
        logic       high;
        logic [4:0] id;
    } ipx_vec_t;

endpackage

// *** sim/ipx_cpu_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// cpu side: returns on request, then one long instruction
// ------------------------------------------------------------
module ipx_cpu_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ret_go,
    output logic      cpu_return_from_interrupt,
    output logic      cpu_insn_done
);
    logic [3:0] ret_q;
    logic [3:0] ins_q;

    // the return takes six clocks before it completes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ret_q    <= 4'h0;
            cpu_return_from_interrupt <= 1'b0;
        end else begin
            cpu_return_from_interrupt <= (ret_q == 4'h1);
            if (ret_go)
                ret_q <= 4'h6;
            else if (ret_q != 4'h0)
                ret_q <= ret_q - 4'h1;
        end
    end

    // a divide of eight clocks follows every return, the worst case
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ins_q         <= 4'h2;
            cpu_insn_done <= 1'b0;
        end else begin
            cpu_insn_done <= (ins_q == 4'h1) && (ret_q != 4'h1);
            if (ret_q == 4'h1)
                ins_q <= 4'h8;
            else if (ins_q <= 4'h1)
                ins_q <= 4'h2;
            else
                ins_q <= ins_q - 4'h1;
        end
    end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
`include "ipx_map.svh"
module tb;
    import ipx_pkg::*;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } ipx_row_t;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic [15:0] src_set;
    logic [7:0]  port_pins;
    logic        cpu_stall;
    logic        cpu_return_from_interrupt;
    logic        cpu_insn_done;
    logic        ret_go;
    ipx_vec_t    vec;
    logic        call_busy;
    logic        irq;
    int          error_cnt;
    int          checks;
    int          vcnt;
    int          n;
    int          i;
    ipx_row_t    rows [9] = '{
        '{1'b0, `IPX_OFF_PRIO0, 32'h0, 32'h0},
        '{1'b0, `IPX_OFF_PRIO1, 32'h0, 32'h0},
        '{1'b0, `IPX_OFF_PRIO2, 32'h0, 32'h0},
        '{1'b1, `IPX_OFF_PRIO1, 32'hffffffff, 32'hff},
        '{1'b1, `IPX_OFF_PRIO1, 32'h0, 32'h0},
        '{1'b1, `IPX_OFF_CFG, 32'hffffffff, 32'h3ff},
        '{1'b1, `IPX_OFF_CFG, 32'h0, 32'h0},
        '{1'b1, 8'h40, 32'hffffffff, 32'h0},
        '{1'b1, `IPX_OFF_IMASK, 32'hffffffff, 32'hf}};

    ipx_ctrl #(.NSRC(16)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .src_set(src_set),
        .port_pins(port_pins), .cpu_stall(cpu_stall),
        .cpu_return_from_interrupt(cpu_return_from_interrupt), .cpu_insn_done(cpu_insn_done),
        .vec(vec), .call_busy(call_busy), .irq(irq));

    ipx_cpu_model u_cpu (
        .hclk(hclk), .hresetn(hresetn), .ret_go(ret_go),
        .cpu_return_from_interrupt(cpu_return_from_interrupt), .cpu_insn_done(cpu_insn_done));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    always @(posedge hclk) if (vec.valid === 1'b1) vcnt <= vcnt + 1;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic rdy;
        int k;
        for (k = 0; k < 20; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        error_cnt++;
        wrap_up();
    endtask

    // one single word transfer, entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    // counts edges until the vector pulse; stalls the cpu for stl clocks
    task automatic wait_vec(input int stl, output int cnt);
        cnt = 0;
        cpu_stall <= (stl != 0);
        while (cnt < 40) begin
            @(posedge hclk);
            cnt++;
            if (cnt == stl) cpu_stall <= 1'b0;
            #1;
            if (vec.valid === 1'b1) break;
        end
        if (cnt == 40) begin
            error_cnt++;
            wrap_up();
        end
        @(posedge hclk);
    endtask

    task automatic ret_wait;
        int k;
        ret_go <= 1'b1;
        @(posedge hclk);
        ret_go <= 1'b0;
        for (k = 0; k < 20; k++) begin
            @(posedge hclk);
            if (cpu_return_from_interrupt === 1'b1) return;
        end
        error_cnt++;
        wrap_up();
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
        {src_set, cpu_stall, ret_go, error_cnt, checks} = '0;
        hsize     = 3'b010;
        port_pins = 8'h08;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({29'h0, hresp, call_busy, irq}, 32'h0);
        for (i = 0; i < 9; i++) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        // external flags track their idle pins in level mode: keep them out
        wr(`IPX_OFF_EN, 32'hfffc);
        wr(`IPX_OFF_CTRL, 32'h1);
        wr(`IPX_OFF_PEND, 32'h20);
        wait_vec(0, n);
        chk(n, 6);
        chk({27'h0, vec.id}, 32'h5);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        rd_chk(`IPX_OFF_ISTAT, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        // high preempts the low routine; two low ones wait behind it
        wr(`IPX_OFF_PRIO0, 32'h08);
        wr(`IPX_OFF_PEND, 32'h58);
        wait_vec(0, n);
        chk(n, 6);
        chk({26'h0, vec.high, vec.id}, 32'h23);
        wr(`IPX_OFF_PEND, 32'h50);
        ret_wait();
        i = vcnt;
        repeat (30) @(posedge hclk);
        chk(vcnt, i);
        ret_wait();
        wait_vec(0, n);
        chk({31'h0, n > 8 && n <= 15}, 32'h1);
        chk({27'h0, vec.id}, 32'h4);
        wr(`IPX_OFF_PEND, 32'h0);
        ret_wait();
        repeat (12) @(posedge hclk);
        wr(`IPX_OFF_PEND, 32'h80);
        wait_vec(4, n);
        chk(n, 10);
        wr(`IPX_OFF_PEND, 32'h0);
        ret_wait();
        repeat (12) @(posedge hclk);
        // stall inside the call; software sets the top source
        wr(`IPX_OFF_PEND, 32'h8000);
        @(posedge hclk);
        cpu_stall <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({31'h0, call_busy}, 32'h1);
        wait_vec(0, n);
        chk(n, 5);
        chk({27'h0, vec.id}, 32'hf);
        wr(`IPX_OFF_PEND, 32'h0);
        ret_wait();
        repeat (12) @(posedge hclk);
        // edge input on pin 2, level input active low on pin 3
        wr(`IPX_OFF_IMASK, 32'h0);
        wr(`IPX_OFF_CFG, 32'h1a5);
        // drop the flag latched while in level mode, then let inputs in
        wr(`IPX_OFF_PEND, 32'h0);
        wr(`IPX_OFF_EN, 32'hffff);
        port_pins <= 8'h0c;
        wait_vec(0, n);
        chk({27'h0, vec.id}, 32'h0);
        rd_chk(`IPX_OFF_PEND, 32'h0);
        chk({31'h0, irq}, 32'h0);
        ret_wait();
        repeat (12) @(posedge hclk);
        port_pins <= 8'h04; // held until recognised
        repeat (4) @(posedge hclk);
        rd_chk(`IPX_OFF_PEND, 32'h2);
        wait_vec(0, n);
        chk({27'h0, vec.id}, 32'h1);
        port_pins <= 8'h0c; // released inside the routine
        repeat (4) @(posedge hclk);
        rd_chk(`IPX_OFF_PEND, 32'h0);
        ret_wait();
        repeat (12) @(posedge hclk);
        // input b to edge mode, then an active-low edge on pin 3
        wr(`IPX_OFF_CFG, 32'h1a7);
        port_pins <= 8'h04;
        wait_vec(0, n);
        chk({27'h0, vec.id}, 32'h1);
        rd_chk(`IPX_OFF_PEND, 32'h0);
        wrap_up();
    end
endmodule
